/* ppc_pkg.sv */
package ppc_pkg;
	// Port slots in order: P0, P2, P3, P4, PA
	localparam int NPORT = 5;
	localparam int P0 = 0;
	localparam int P2 = 1;
	localparam int P4 = 3;
	localparam int PA = 4;
	// Implemented bits of each port
	localparam logic [7:0] PORT_MASK [NPORT] = '{8'hFF, 8'h7F, 8'h7F, 8'h3F, 8'hFF};
	// Field index inside a port slot
	localparam logic [2:0] F_OUT = 3'h0;
	localparam logic [2:0] F_DIR = 3'h1;
	localparam logic [2:0] F_PULL = 3'h2;
	localparam logic [2:0] F_OD = 3'h3;
	localparam logic [2:0] F_OMD = 3'h4;
	localparam logic [2:0] F_LED = 3'h5;
	localparam logic [2:0] F_POL = 3'h6;
	localparam logic [2:0] F_PIN = 3'h7;
	// Miscellaneous slot and its fields
	localparam logic [2:0] S_MISC = 3'h5;
	localparam logic [2:0] M_AN_LO = 3'h0;
	localparam logic [2:0] M_AN_HI = 3'h1;
	localparam logic [2:0] M_IRQ_EN = 3'h2;
	localparam logic [2:0] M_EDGE_LO = 3'h3;
	localparam logic [2:0] M_EDGE_HI = 3'h4;
	localparam logic [2:0] M_KEY = 3'h5;
	localparam logic [2:0] M_STAT = 3'h6;
	// Register index sits in haddr[7:2]
	localparam int IDX_LSB = 2;
	localparam int IDX_W = 6;
	localparam int NREG = 48;
	localparam logic [7:0] REG_RST = 8'h00;
	localparam logic [2:0] SIZE_WORD = 3'h2;
	localparam int HTRANS_ACT = 1;
	// Writable bit masks
	localparam logic [7:0] MASK_NONE = 8'h00;
	localparam logic [7:0] MASK_FULL = 8'hFF;
	localparam logic [7:0] MASK_AN_HI = 8'h0F;
	localparam logic [7:0] MASK_IRQ = 8'h1F;
	localparam logic [7:0] MASK_EDGE_HI = 8'h03;
	localparam logic [7:0] MASK_POL = 8'h01;
	// Status register bits
	localparam int ST_RUN = 0;
	localparam int ST_AUTO = 1;
	// External interrupt edge codes
	localparam int NIRQ = 5;
	localparam int BOTH_MIN = 2;
	localparam logic [1:0] EDGE_FALL = 2'h0;
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_BOTH = 2'h2;
	// Clock settle wait after reset release
	localparam int CLK_PERIOD_NS = 5;
	localparam int STAB_TIME_NS = 1000;
	localparam int STAB_CYCLES = (STAB_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 8;
	localparam logic [CNT_W-1:0] WAIT_LAST = CNT_W'(STAB_CYCLES - 1);
	// Reset sequencer states
	typedef enum logic [1:0] {
		RS_HOLD = 2'b00,
		RS_WAIT = 2'b01,
		RS_RUN  = 2'b10
	} ppc_rst_state_t;
	// Pad drive bundle of one port
	typedef struct packed {
		logic [7:0] o;
		logic [7:0] oe;
		logic [7:0] pu;
		logic [7:0] pd;
		logic [7:0] led;
		logic [7:0] an;
	} ppc_pad_out_t;
	// Alternate function request of one port
	typedef struct packed {
		logic [7:0] sel;
		logic [7:0] dat;
	} ppc_alt_t;
	// Configuration of one port
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] dir;
		logic [7:0] pull;
		logic [7:0] pol;
		logic [7:0] od;
		logic [7:0] omd;
		logic [7:0] led;
		logic [7:0] an;
	} ppc_cfg_t;
	// Register index from slot and field
	function automatic logic [5:0] ppc_ridx(input logic [2:0] slot, input logic [2:0] fld);
		return {slot, fld};
	endfunction
	// Writable bits of a register, zero when unmapped
	function automatic logic [7:0] ppc_wmask(input logic [5:0] idx);
		logic [2:0] s;
		logic [2:0] f;
		logic [7:0] m;
		s = idx[5:3];
		f = idx[2:0];
		m = MASK_NONE;
		if (int'(s) < NPORT) begin
			if (f <= F_OMD) m = PORT_MASK[s];
			else if (f == F_LED && (int'(s) == P0 || int'(s) == PA)) m = MASK_FULL;
			else if (f == F_POL && int'(s) == P4) m = MASK_POL;
		end else if (s == S_MISC) begin
			case (f)
				M_AN_LO, M_EDGE_LO, M_KEY: m = MASK_FULL;
				M_AN_HI: m = MASK_AN_HI;
				M_IRQ_EN: m = MASK_IRQ;
				M_EDGE_HI: m = MASK_EDGE_HI;
				default: m = MASK_NONE;
			endcase
		end
		return m;
	endfunction
endpackage

/* ppc_pin_cell.sv */
`timescale 1ns/10ps

module ppc_pin_cell #(
	parameter logic [7:0] MASK = 8'hFF
) (
	input  wire logic                  core_clk, // System clock
	input  wire logic                  rst_n,    // Sync reset
	input  wire ppc_pkg::ppc_cfg_t     cfg,      // Port setup
	input  wire ppc_pkg::ppc_alt_t     alt,      // Peripheral drive
	input  wire logic [7:0]            pad_i,    // Pin levels
	output ppc_pkg::ppc_pad_out_t      pad_q,    // Pad controls
	output logic [7:0]                 level_q,  // Pin read value
	output logic [7:0]                 evt_q     // Timer event inputs
);
	logic [7:0] sync1_q;  // First sync stage
	logic [7:0] sync2_q;  // Second sync stage
	logic [7:0] use_alt;  // Special function picked
	logic [7:0] val;      // Value to drive
	logic [7:0] drive;    // Bits allowed to drive

	// Source of output value per bit
	always_comb begin
		use_alt = cfg.omd | alt.sel;
		val = (use_alt & alt.dat) | (~use_alt & cfg.out);
		drive = cfg.dir & ~cfg.an & MASK;
	end

	// Two-stage pin synchroniser
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			sync1_q <= '0;
			sync2_q <= '0;
		end else begin
			sync1_q <= pad_i;
			sync2_q <= sync1_q;
		end
	end

	// Pad drive, pulls, LED and analog
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			pad_q <= '0;
		end else begin
			pad_q.o <= val & ~cfg.od & MASK;
			pad_q.oe <= drive & (~cfg.od | ~val);
			pad_q.pu <= cfg.pull & cfg.pol & MASK;
			pad_q.pd <= cfg.pull & ~cfg.pol & MASK;
			pad_q.led <= cfg.led & cfg.dir & MASK;
			pad_q.an <= cfg.an & MASK;
		end
	end

	// Read value and event inputs
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			level_q <= '0;
			evt_q <= '0;
		end else begin
			level_q <= sync2_q & ~cfg.an & MASK;
			evt_q <= sync2_q & ~cfg.dir & ~cfg.an & MASK;
		end
	end

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	property p_oe_dir;
		(pad_q.oe & ~$past(cfg.dir)) == '0;
	endproperty
	a_oe_dir: assert property (p_oe_dir) else $error("Pin driven while input");
	property p_od_low;
		(pad_q.o & $past(cfg.od)) == '0;
	endproperty
	a_od_low: assert property (p_od_low) else $error("Open drain drove high");
	property p_pull_mix;
		(pad_q.pu & pad_q.pd) == '0;
	endproperty
	a_pull_mix: assert property (p_pull_mix) else $error("Pull up and down mixed");
	property p_evt_in;
		(evt_q & $past(cfg.dir)) == '0;
	endproperty
	a_evt_in: assert property (p_evt_in) else $error("Event seen on output");
	property p_an_hiz;
		(pad_q.oe & pad_q.an) == '0;
	endproperty
	a_an_hiz: assert property (p_an_hiz) else $error("Analog pin driven");
	property p_gpio;
		((pad_q.o ^ $past(cfg.out))
			& $past(cfg.dir & ~cfg.omd & ~alt.sel & ~cfg.od & ~cfg.an)) == '0;
	endproperty
	a_gpio: assert property (p_gpio) else $error("Output differs from latch");
endmodule

/* ppc_port_ctrl.sv */
// Our own choices: the register offsets and register access over AHB-Lite.
`timescale 1ns/10ps

module ppc_port_ctrl (
	input  wire logic                  core_clk,               // System clock
	input  wire logic                  rst_n,                  // Sync reset
	input  wire logic                  hsel,                   // Slave select
	input  wire logic [31:0]           haddr,                  // Byte address
	input  wire logic [1:0]            htrans,                 // Transfer type
	input  wire logic                  hwrite,                 // Write strobe
	input  wire logic [2:0]            hsize,                  // Transfer size
	input  wire logic [31:0]           hwdata,                 // Write data
	input  wire logic                  hready,                 // Bus ready
	output logic                       hreadyout,              // Slave ready
	output logic [31:0]                hrdata,                 // Read data
	output logic                       hresp,                  // Response
	input  wire logic [7:0]            pad_i [ppc_pkg::NPORT], // Pin levels
	output ppc_pkg::ppc_pad_out_t      pad_out [ppc_pkg::NPORT], // Pad controls
	input  wire ppc_pkg::ppc_alt_t     alt_in [ppc_pkg::NPORT], // Peripheral drive
	output logic [7:0]                 pin_level [ppc_pkg::NPORT], // Pin values
	output logic [7:0]                 evt_in [ppc_pkg::NPORT], // Event inputs
	input  wire logic                  reset_n_pin,            // Port 2 bit 7 pin
	input  wire logic                  auto_reset_setting_pin, // Auto-reset strap
	output logic                       auto_reset_en,          // Auto reset on
	output logic                       core_rst_n,             // Core released
	output logic                       reset_irq_req,          // Reset event
	output logic [4:0]                 ext_irq_req,            // Edge events
	output logic                       key_irq_req             // Key event
);
	// Register file, one byte per word
	logic [7:0] regs_q [ppc_pkg::NREG];
	// Reset pin and strap synchronisers
	logic rp_s1_q;
	logic rp_s2_q;
	logic ar_s1_q;
	logic ar_s2_q;
	// Reset sequencer
	ppc_pkg::ppc_rst_state_t st_q;
	logic [ppc_pkg::CNT_W-1:0] wait_q;  // Settle counter
	logic wait_done;                    // Last settle cycle
	logic cell_rst_n;                   // Pin logic reset
	// Bus address phase
	logic take;                         // Transfer accepted
	logic a_hit;                        // Mapped word access
	logic [5:0] a_idx;                  // Register index
	logic [7:0] rd_byte;                // Read value
	logic wr_q;                         // Write data phase
	logic [5:0] widx_q;                 // Write index
	logic hreadyout_q;
	logic [31:0] hrdata_q;
	logic hresp_q;
	logic auto_q;
	logic core_rst_n_q;
	logic reset_irq_q;
	// Interrupt detection
	logic [4:0] irq_lvl;                // Port 2 low bits
	logic [4:0] irq_prev_q;             // Previous levels
	logic [4:0] irq_d;                  // Edge matches
	logic [4:0] irq_q;
	logic [9:0] edge_cfg;               // Two bits per input
	logic key_act;                      // Any key pressed
	logic key_prev_q;
	logic key_q;
	logic [ppc_pkg::CNT_W-1:0] chk_q;   // Helper settle count

	// Reset pin sync; also port 2 bit 7 read
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			rp_s1_q <= 1'b0;
			rp_s2_q <= 1'b0;
		end else begin
			rp_s1_q <= reset_n_pin;
			rp_s2_q <= rp_s1_q;
		end
	end

	// Auto-reset strap sync and output
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			ar_s1_q <= 1'b0;
			ar_s2_q <= 1'b0;
			auto_q <= 1'b0;
		end else begin
			ar_s1_q <= auto_reset_setting_pin;
			ar_s2_q <= ar_s1_q;
			auto_q <= ar_s2_q;
		end
	end

	// Settle wait ends here
	always_comb begin
		wait_done = (st_q == ppc_pkg::RS_WAIT) && (wait_q == ppc_pkg::WAIT_LAST);
		cell_rst_n = (st_q != ppc_pkg::RS_HOLD);
	end

	// Hold while pin low, then settle wait
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			st_q <= ppc_pkg::RS_HOLD;
			wait_q <= '0;
		end else begin
			unique case (st_q)
				// Pin low keeps state initialised
				ppc_pkg::RS_HOLD: begin
					wait_q <= '0;
					if (rp_s2_q) st_q <= ppc_pkg::RS_WAIT;
				end
				// Count clock settle time
				ppc_pkg::RS_WAIT: begin
					if (!rp_s2_q) st_q <= ppc_pkg::RS_HOLD;
					else if (wait_done) st_q <= ppc_pkg::RS_RUN;
					else wait_q <= wait_q + 1'b1;
				end
				// Normal operation
				ppc_pkg::RS_RUN: begin
					if (!rp_s2_q) st_q <= ppc_pkg::RS_HOLD;
				end
				// Illegal code recovers to hold
				default: st_q <= ppc_pkg::RS_HOLD;
			endcase
		end
	end

	// Core release and reset event
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			core_rst_n_q <= 1'b0;
			reset_irq_q <= 1'b0;
		end else begin
			// Never release the core while the pin is low
			core_rst_n_q <= rp_s2_q && (wait_done || st_q == ppc_pkg::RS_RUN);
			reset_irq_q <= wait_done && rp_s2_q;
		end
	end

	// Address phase decode
	always_comb begin
		a_idx = haddr[ppc_pkg::IDX_LSB +: ppc_pkg::IDX_W];
		take = hsel & hready & htrans[ppc_pkg::HTRANS_ACT];
		a_hit = (haddr[31:ppc_pkg::IDX_LSB+ppc_pkg::IDX_W] == '0)
			&& (hsize == ppc_pkg::SIZE_WORD)
			&& (int'(a_idx) < ppc_pkg::NREG)
			&& (haddr[ppc_pkg::IDX_LSB-1:0] == '0);
	end

	// Read value, with forwarding of a pending write
	always_comb begin
		rd_byte = '0;
		if (a_hit) begin
			rd_byte = regs_q[a_idx] & ppc_pkg::ppc_wmask(a_idx);
			// Pin level register of a port
			if (a_idx[2:0] == ppc_pkg::F_PIN && int'(a_idx[5:3]) < ppc_pkg::NPORT) begin
				rd_byte = pin_level[a_idx[5:3]];
				if (int'(a_idx[5:3]) == ppc_pkg::P2) rd_byte[7] = rp_s2_q;
			end
			// Status register
			if (a_idx == ppc_pkg::ppc_ridx(ppc_pkg::S_MISC, ppc_pkg::M_STAT)) begin
				rd_byte[ppc_pkg::ST_RUN] = core_rst_n_q;
				rd_byte[ppc_pkg::ST_AUTO] = auto_q;
			end
			// Write still in its data phase
			if (wr_q && widx_q == a_idx && ppc_pkg::ppc_wmask(a_idx) != '0)
				rd_byte = hwdata[7:0] & ppc_pkg::ppc_wmask(a_idx);
		end
	end

	// Bus slave: zero wait, always OKAY
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			wr_q <= 1'b0;
			widx_q <= '0;
			hrdata_q <= '0;
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
		end else begin
			wr_q <= take & hwrite & a_hit;
			widx_q <= a_idx;
			hrdata_q <= (take & ~hwrite) ? 32'(rd_byte) : '0;
			hreadyout_q <= 1'b1;
			hresp_q <= 1'b0;
		end
	end

	// Register writes; cleared while reset pin holds
	always_ff @(posedge core_clk) begin
		if (!rst_n || st_q == ppc_pkg::RS_HOLD) begin
			for (int i = 0; i < ppc_pkg::NREG; i++) regs_q[i] <= ppc_pkg::REG_RST;
		end else if (wr_q) begin
			regs_q[widx_q] <= hwdata[7:0] & ppc_pkg::ppc_wmask(widx_q);
		end
	end

	// One pin cell per port
	for (genvar p = 0; p < ppc_pkg::NPORT; p++) begin : g_port
		ppc_pkg::ppc_cfg_t cfg;   // Setup of this port
		logic [7:0] an_bits;      // Analog selects
		logic [7:0] pol_bits;     // Pull polarity
		// Analog inputs sit on port A and port 4
		if (p == ppc_pkg::PA) begin : g_an_a
			assign an_bits = regs_q[ppc_pkg::ppc_ridx(ppc_pkg::S_MISC, ppc_pkg::M_AN_LO)];
		end else if (p == ppc_pkg::P4) begin : g_an_4
			logic [7:0] hi;
			assign hi = regs_q[ppc_pkg::ppc_ridx(ppc_pkg::S_MISC, ppc_pkg::M_AN_HI)];
			assign an_bits = {2'b00, hi[0], hi[1], hi[2], hi[3], 2'b00};
		end else begin : g_an_n
			assign an_bits = '0;
		end
		// One polarity for all of port 4
		if (p == ppc_pkg::P4) begin : g_pol
			assign pol_bits = {8{regs_q[ppc_pkg::ppc_ridx(3'(p), ppc_pkg::F_POL)][0]}};
		end else begin : g_pol_up
			assign pol_bits = '1;
		end
		// Gather the port setup
		always_comb begin
			cfg.out = regs_q[ppc_pkg::ppc_ridx(3'(p), ppc_pkg::F_OUT)];
			cfg.dir = regs_q[ppc_pkg::ppc_ridx(3'(p), ppc_pkg::F_DIR)];
			cfg.pull = regs_q[ppc_pkg::ppc_ridx(3'(p), ppc_pkg::F_PULL)];
			cfg.pol = pol_bits;
			cfg.od = regs_q[ppc_pkg::ppc_ridx(3'(p), ppc_pkg::F_OD)];
			cfg.omd = regs_q[ppc_pkg::ppc_ridx(3'(p), ppc_pkg::F_OMD)];
			cfg.led = regs_q[ppc_pkg::ppc_ridx(3'(p), ppc_pkg::F_LED)];
			cfg.an = an_bits;
		end
		ppc_pin_cell #(
			.MASK (ppc_pkg::PORT_MASK[p])
		) u_cell (
			.core_clk (core_clk),
			.rst_n    (cell_rst_n),
			.cfg      (cfg),
			.alt      (alt_in[p]),
			.pad_i    (pad_i[p]),
			.pad_q    (pad_out[p]),
			.level_q  (pin_level[p]),
			.evt_q    (evt_in[p])
		);
	end

	// Edge selection per external input
	always_comb begin
		irq_lvl = pin_level[ppc_pkg::P2][4:0];
		edge_cfg = {regs_q[ppc_pkg::ppc_ridx(ppc_pkg::S_MISC, ppc_pkg::M_EDGE_HI)][1:0],
			regs_q[ppc_pkg::ppc_ridx(ppc_pkg::S_MISC, ppc_pkg::M_EDGE_LO)]};
		for (int i = 0; i < ppc_pkg::NIRQ; i++) begin
			case (edge_cfg[2*i +: 2])
				// Rising edge only
				ppc_pkg::EDGE_RISE: irq_d[i] = irq_lvl[i] & ~irq_prev_q[i];
				// Both edges on inputs 2 to 4
				ppc_pkg::EDGE_BOTH: irq_d[i] = (i >= ppc_pkg::BOTH_MIN) ?
					(irq_lvl[i] ^ irq_prev_q[i]) : (~irq_lvl[i] & irq_prev_q[i]);
				// Falling edge otherwise
				default: irq_d[i] = ~irq_lvl[i] & irq_prev_q[i];
			endcase
		end
	end

	// External interrupt pulses
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			irq_prev_q <= '0;
			irq_q <= '0;
		end else begin
			irq_prev_q <= irq_lvl;
			irq_q <= irq_d & regs_q[ppc_pkg::ppc_ridx(ppc_pkg::S_MISC, ppc_pkg::M_IRQ_EN)][4:0];
		end
	end

	// Any enabled key pulled low
	always_comb begin
		key_act = |(regs_q[ppc_pkg::ppc_ridx(ppc_pkg::S_MISC, ppc_pkg::M_KEY)]
			& ~pin_level[ppc_pkg::PA]);
	end

	// Key interrupt on start of a press
	always_ff @(posedge core_clk) begin
		if (!rst_n) begin
			key_prev_q <= 1'b0;
			key_q <= 1'b0;
		end else begin
			key_prev_q <= key_act;
			key_q <= key_act & ~key_prev_q;
		end
	end

	// Helper count of settle cycles
	always_ff @(posedge core_clk) begin
		if (!rst_n) chk_q <= '0;
		else if (st_q == ppc_pkg::RS_WAIT) chk_q <= chk_q + 1'b1;
		else chk_q <= '0;
	end

	// Outputs straight from flops
	assign hreadyout = hreadyout_q;
	assign hrdata = hrdata_q;
	assign hresp = hresp_q;
	assign auto_reset_en = auto_q;
	assign core_rst_n = core_rst_n_q;
	assign reset_irq_req = reset_irq_q;
	assign ext_irq_req = irq_q;
	assign key_irq_req = key_q;

	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	localparam int STAB_C = ppc_pkg::STAB_CYCLES;

	property p_settle;
		reset_irq_req |-> (chk_q == STAB_C) && !$past(core_rst_n);
	endproperty
	a_settle: assert property (p_settle) else $error("Settle wait wrong");
	property p_hold;
		(st_q == ppc_pkg::RS_HOLD) |=> (pad_out[ppc_pkg::P0].oe == '0)
			&& (pad_out[ppc_pkg::P0].pu == '0) && (pad_out[ppc_pkg::PA].oe == '0);
	endproperty
	a_hold: assert property (p_hold) else $error("Pins not floating in reset");
	property p_hold_core;
		!rp_s2_q |=> !core_rst_n;
	endproperty
	a_hold_core: assert property (p_hold_core) else $error("Core ran with pin low");
	property p_auto;
		($past(rst_n) && $past(rst_n, 2) && $past(rst_n, 3))
			|-> auto_reset_en == $past(auto_reset_setting_pin, 3);
	endproperty
	a_auto: assert property (p_auto) else $error("Auto reset level wrong");
	property p_rise1;
		(irq_q[1] == 1'b0) ##1 ($rose(pin_level[ppc_pkg::P2][1]) && edge_cfg[3:2] ==
			ppc_pkg::EDGE_RISE && regs_q[ppc_pkg::ppc_ridx(ppc_pkg::S_MISC,
			ppc_pkg::M_IRQ_EN)][1]) |=> ext_irq_req[1];
	endproperty
	a_rise1: assert property (p_rise1) else $error("Rising edge missed");
	property p_both1;
		(edge_cfg[3:2] == ppc_pkg::EDGE_BOTH && $rose(pin_level[ppc_pkg::P2][1]))
			|=> !ext_irq_req[1];
	endproperty
	a_both1: assert property (p_both1) else $error("Input 1 fired on rise");
	property p_key;
		key_irq_req |-> $past(key_act) && !$past(key_act, 2);
	endproperty
	a_key: assert property (p_key) else $error("Key event without press");
	property p_p4_bits;
		(pad_out[ppc_pkg::P4].oe & ~ppc_pkg::PORT_MASK[ppc_pkg::P4]) == '0;
	endproperty
	a_p4_bits: assert property (p_p4_bits) else $error("Absent port bit driven");

	c_irq_both: cover property (ext_irq_req[2] && $past(edge_cfg[5:4]) == ppc_pkg::EDGE_BOTH);
	c_key: cover property (key_irq_req);
	c_release: cover property (reset_irq_req ##1 core_rst_n);
	c_od: cover property (pad_out[ppc_pkg::P0].oe[0] && !pad_out[ppc_pkg::P0].o[0]);
endmodule

/* ppc_pin_model.sv */
`timescale 1ns/10ps

// Board side of the pins: pad drive, outside drivers, pulls
module ppc_pin_model (
	input  wire logic                  core_clk, // System clock
	input  wire ppc_pkg::ppc_pad_out_t pad_out [ppc_pkg::NPORT], // Pad controls
	input  wire logic [7:0]            ext_en [ppc_pkg::NPORT],  // Outside drive on
	input  wire logic [7:0]            ext_val [ppc_pkg::NPORT], // Outside level
	output logic [7:0]                 pad_i [ppc_pkg::NPORT]    // Pin levels
);
	logic [7:0] float_q; // Wandering level of a floating pin

	// Floating lines never keep a stale value
	initial float_q = 8'h5A;
	always @(posedge core_clk) float_q <= ~float_q;

	// Pad drive first, then outside driver, then pulls
	always_comb begin
		for (int p = 0; p < ppc_pkg::NPORT; p++) begin
			for (int b = 0; b < 8; b++) begin
				if (pad_out[p].oe[b]) pad_i[p][b] = pad_out[p].o[b];
				else if (ext_en[p][b]) pad_i[p][b] = ext_val[p][b];
				else if (pad_out[p].pu[b]) pad_i[p][b] = 1'b1;
				else if (pad_out[p].pd[b]) pad_i[p][b] = 1'b0;
				else pad_i[p][b] = float_q[b];
			end
		end
	end
endmodule

/* test_port_pin_control.sv */
`timescale 1ns/10ps

`define CHK(g, e) begin checks++; if ((g) !== (e)) begin error_cnt++; \
	$display("mismatch t=%0t got %h want %h", $time, g, e); end end

module test_port_pin_control;
	// Slot, field, readback after writing all ones
	typedef struct packed {
		logic [2:0]  s;
		logic [2:0]  f;
		logic [31:0] e;
	} ppc_row_t;
	logic core_clk, rst_n, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [4:0] ext_irq_req;
	logic reset_n_pin, auto_reset_setting_pin, auto_reset_en, core_rst_n;
	logic reset_irq_req, key_irq_req;
	logic [7:0] pad_i [ppc_pkg::NPORT];
	ppc_pkg::ppc_pad_out_t pad_out [ppc_pkg::NPORT];
	ppc_pkg::ppc_alt_t alt_in [ppc_pkg::NPORT];
	logic [7:0] pin_level [ppc_pkg::NPORT];
	logic [7:0] evt_in [ppc_pkg::NPORT];
	logic [7:0] ext_en [ppc_pkg::NPORT];
	logic [7:0] ext_val [ppc_pkg::NPORT];
	int error_cnt, checks, n, key_cnt, rst_cnt;
	int irq_cnt [5];
	int irq_exp [5] = '{1, 1, 2, 1, 0}; // Fall, rise, both, fall, disabled
	int irq_exp2 [5] = '{1, 1, 1, 1, 0}; // Fall, both as fall, rise, fall, off
	ppc_row_t rows [11] = '{
		'{3'h0, 3'h1, 32'hFF}, '{3'h1, 3'h1, 32'h7F}, '{3'h2, 3'h2, 32'h7F},
		'{3'h3, 3'h2, 32'h3F}, '{3'h4, 3'h5, 32'hFF}, '{3'h1, 3'h5, 32'h00},
		'{3'h3, 3'h6, 32'h01}, '{3'h5, 3'h1, 32'h0F}, '{3'h5, 3'h2, 32'h1F},
		'{3'h5, 3'h4, 32'h03}, '{3'h5, 3'h7, 32'h00}};

	ppc_port_ctrl dut_u (.core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .pad_i, .pad_out,
		.alt_in, .pin_level, .evt_in, .reset_n_pin, .auto_reset_setting_pin,
		.auto_reset_en, .core_rst_n, .reset_irq_req, .ext_irq_req, .key_irq_req);
	ppc_pin_model pins_u (.core_clk, .pad_out, .ext_en, .ext_val, .pad_i);

	// Clock of 5 ns
	initial begin
		core_clk = 1'b0;
		forever #2.5 core_clk = ~core_clk;
	end

	// Count one-cycle event pulses
	always @(posedge core_clk) begin
		for (int i = 0; i < 5; i++) if (ext_irq_req[i] === 1'b1) irq_cnt[i]++;
		if (key_irq_req === 1'b1) key_cnt++;
		if (reset_irq_req === 1'b1) rst_cnt++;
	end

	// Verdict and end of run
	task automatic test_done();
		if (error_cnt == 0 && checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// Bounded wait for the slave's ready at a rising edge
	task automatic rdy();
		int k;
		k = 0;
		do begin
			@(posedge core_clk);
			k++;
		end while (hreadyout !== 1'b1 && k < 20);
		if (k >= 20) begin
			error_cnt++;
			test_done();
		end
	endtask

	// One single word transfer, address from slot and field
	task automatic bus(input logic [2:0] s, input logic [2:0] f, input logic w,
		input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, s, f, 2'h0};
		hwrite <= w;
		hsize <= ppc_pkg::SIZE_WORD;
		rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		rdy();
		rd = hrdata;
	endtask

	// Bounded wait for the core to run, cycles kept in n
	task automatic wait_core();
		n = 0;
		while (core_rst_n !== 1'b1 && n < 400) begin
			@(posedge core_clk);
			n++;
		end
		if (n >= 400) begin
			error_cnt++;
			test_done();
		end
	endtask

	// Main sequence
	initial begin
		{rst_n, hsel, haddr, htrans, hwrite, hsize, hwdata} = '0;
		reset_n_pin = 1'b1;
		auto_reset_setting_pin = 1'b1;
		alt_in = '{default: '0};
		ext_en = '{8'h00, 8'h1F, 8'h7F, 8'h00, 8'hFF};
		ext_val = '{8'hFF, 8'h1F, 8'h55, 8'hFF, 8'hFF};
		repeat (6) @(posedge core_clk);
		rst_n <= 1'b1;
		wait_core();
		// Table: reset value, then masked readback
		foreach (rows[i]) begin
			bus(rows[i].s, rows[i].f, 1'b0, 32'h0);
			`CHK(rd, 32'h0)
			bus(rows[i].s, rows[i].f, 1'b1, 32'hFFFFFFFF);
			bus(rows[i].s, rows[i].f, 1'b0, 32'h0);
			`CHK(rd, rows[i].e)
		end
		`CHK(hresp, 1'b0)
		// Strap level and status
		`CHK(auto_reset_en, 1'b1)
		bus(3'h5, 3'h6, 1'b0, 32'h0);
		`CHK(rd, 32'h3)
		auto_reset_setting_pin <= 1'b0;
		repeat (5) @(posedge core_clk);
		`CHK(auto_reset_en, 1'b0)
		// Bus reset clears the setup
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		wait_core();
		bus(3'h0, 3'h1, 1'b0, 32'h0);
		`CHK(rd, 32'h0)
		// Port 0: latch, alternate bit 0, open drain high half, pulls, LED
		bus(3'h0, 3'h0, 1'b1, 32'hA5);
		bus(3'h0, 3'h1, 1'b1, 32'hFF);
		bus(3'h0, 3'h3, 1'b1, 32'hF0);
		bus(3'h0, 3'h2, 1'b1, 32'hCF);
		bus(3'h0, 3'h5, 1'b1, 32'hF0);
		bus(3'h0, 3'h4, 1'b1, 32'h01);
		alt_in[0] <= '{8'h40, 8'h40};
		repeat (2) @(posedge core_clk);
		`CHK(pad_out[0].oe, 8'h1F)
		`CHK(pad_out[0].o & 8'h0F, 8'h04)
		`CHK(pad_out[0].pu, 8'hCF)
		`CHK(pad_out[0].led, 8'hF0)
		// Port 3 inputs read the pins, event path gated by direction
		`CHK(pin_level[2], 8'h55)
		`CHK(evt_in[2], 8'h55)
		bus(3'h2, 3'h7, 1'b0, 32'h0);
		`CHK(rd, 32'h55)
		bus(3'h2, 3'h1, 1'b1, 32'h0F);
		bus(3'h2, 3'h4, 1'b1, 32'h03);
		alt_in[2] <= '{8'h00, 8'h01};
		repeat (5) @(posedge core_clk);
		`CHK(evt_in[2], 8'h50)
		`CHK(pad_out[2].o, 8'h01)
		// Port 4 pulls down, then all up
		bus(3'h3, 3'h2, 1'b1, 32'h3F);
		repeat (2) @(posedge core_clk);
		`CHK({pad_out[3].pu, pad_out[3].pd}, 16'h003F)
		bus(3'h3, 3'h6, 1'b1, 32'h01);
		repeat (2) @(posedge core_clk);
		`CHK({pad_out[3].pu, pad_out[3].pd}, 16'h3F00)
		// Analog on PA0, then key 1 only
		bus(3'h5, 3'h0, 1'b1, 32'h01);
		repeat (5) @(posedge core_clk);
		`CHK(pad_out[4].an, 8'h01)
		`CHK(pin_level[4], 8'hFE)
		bus(3'h5, 3'h5, 1'b1, 32'h02);
		key_cnt = 0;
		ext_val[4] <= 8'hFC;
		repeat (8) @(posedge core_clk);
		`CHK(key_cnt, 1)
		// Every edge code, irq4 left disabled
		bus(3'h5, 3'h3, 1'b1, 32'hE4);
		bus(3'h5, 3'h2, 1'b1, 32'h0F);
		irq_cnt = '{default: 0};
		ext_val[1] <= 8'h00;
		repeat (8) @(posedge core_clk);
		ext_val[1] <= 8'h1F;
		repeat (8) @(posedge core_clk);
		foreach (irq_exp[i]) `CHK(irq_cnt[i], irq_exp[i])
		// Input 1 takes the both code as falling
		bus(3'h5, 3'h3, 1'b1, 32'h1B);
		irq_cnt = '{default: 0};
		ext_val[1] <= 8'h00;
		repeat (8) @(posedge core_clk);
		ext_val[1] <= 8'h1F;
		repeat (8) @(posedge core_clk);
		foreach (irq_exp2[i]) `CHK(irq_cnt[i], irq_exp2[i])
		// Port 2 bit 7 input only, reads the reset pin
		bus(3'h1, 3'h1, 1'b1, 32'hFF);
		repeat (5) @(posedge core_clk);
		`CHK(pad_out[1].oe, 8'h7F)
		bus(3'h1, 3'h7, 1'b0, 32'h0);
		`CHK(rd, 32'h80)
		// Reset pin holds, then the settle wait
		reset_n_pin <= 1'b0;
		repeat (6) @(posedge core_clk);
		`CHK(core_rst_n, 1'b0)
		`CHK(pad_out[0].oe, 8'h00)
		rst_cnt = 0;
		reset_n_pin <= 1'b1;
		wait_core();
		`CHK(n >= ppc_pkg::STAB_CYCLES && n <= ppc_pkg::STAB_CYCLES + 6, 1'b1)
		repeat (2) @(posedge core_clk);
		`CHK(rst_cnt, 1)
		bus(3'h0, 3'h0, 1'b0, 32'h0);
		`CHK(rd, 32'h0)
		test_done();
	end
endmodule
